/* File: rtl/vms_defines.vh */
`ifndef VMS_DEFINES_VH
`define VMS_DEFINES_VH

// ----------------------------------------------------------------
// Register indices on the indexed I/O port
// ----------------------------------------------------------------
`define VMS_IDX_PRI_OFS   8'h09
`define VMS_IDX_ALT_OFS   8'h0A
`define VMS_IDX_MEM_CFG   8'h0B
`define VMS_IDX_VID_SEL   8'h0C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VMS_RST_BYTE      8'h00

// ----------------------------------------------------------------
// Memory size/map config fields
// ----------------------------------------------------------------
`define VMS_MC_SIZE_HI    7
`define VMS_MC_SIZE_LO    6
`define VMS_MC_MAP_HI     5
`define VMS_MC_MAP_LO     4
`define VMS_MC_ALT_EN     3
`define VMS_MC_WIDE       2
`define VMS_MC_RSVD       1
`define VMS_MC_ROM_OUT    0

// ----------------------------------------------------------------
// Video select fields
// ----------------------------------------------------------------
`define VMS_VS_ALT_VEND   7
`define VMS_VS_COMPAT     6
`define VMS_VS_MAP_SEL    5
`define VMS_VS_CCLK_HI    4
`define VMS_VS_CCLK_LO    3
`define VMS_VS_ULINE      2
`define VMS_VS_CLK_SEL    1
`define VMS_VS_FORCE_CLK  0

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define VMS_SIZE_STD      2'b00
`define VMS_SIZE_EXT256   2'b01
`define VMS_SIZE_512      2'b10
`define VMS_SIZE_1024     2'b11
`define VMS_MODE_BYTE     2'b00
`define VMS_MODE_WORD     2'b01
`define VMS_MODE_DWORD    2'b10
`define VMS_MAP_64K       2'b00
`define VMS_MAP_256K      2'b01
`define VMS_MAP_512K      2'b10
`define VMS_MAP_1024K     2'b11
`define VMS_CCLK_STD      2'b00
`define VMS_CCLK_7        2'b01
`define VMS_CCLK_9        2'b10
`define VMS_CCLK_10       2'b11
`define VMS_DOTS_7        4'h7
`define VMS_DOTS_9        4'h9
`define VMS_DOTS_10       4'hA
`define VMS_PAN_ZERO10    4'h9
`define VMS_PAN_ONE10     4'h8
`define VMS_PAN_BASE10    4'h2
`define VMS_SEG_A000      4'hA
`define VMS_SEG_C000      4'hC
`define VMS_SEG_4000      4'h4
`define VMS_SEG_8000      4'h8
`define VMS_PLANE2        2'b10
`define VMS_PLANE3        2'b11

`endif

/* File: rtl/vms_memory_map_select.v */
`timescale 1ns/1ns
`include "vms_defines.vh"

// Behaviour
// - Standard 256K: fixed VGA address pattern
// - Extended 256K: high bits fold to 1/0
// - 512K: bank bit 16 per mode
// - 1024K: bits through 17, folded low
// - Word mode: page select bit replaces A16
// - Word mode: CA13 for CA15 unless flagged
// - Map field decodes host address window
// - Wide select low in text/packed modes
// - ROM map-out strapped from data pin 0
// - Compatibility and alternate-vendor mode bits
// - Character map plane from select bits
// - Page mode overrides map plane choice
// - Character clock width field in text
// - Ten-dot panning value translation
// - Underline odd codes, clear background bit 3
// - Clock select out or mux lock by strap
// - Force full clock for CRTC timing
// - Host 20-bit, counter 18-bit addresses
// - Seven-bit offsets added to host 18:12
// - Mapping control forces standard mapping
module vms_memory_map_select
(
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  // Indexed register port
  input  wire        i_reg_wr,
  input  wire [7:0]  i_reg_index,
  input  wire [7:0]  i_reg_wdata,
  output reg  [7:0]  o_reg_rdata,
  // Offset registers and mode inputs from sibling logic
  input  wire [6:0]  i_primary_offset_reg,
  input  wire [6:0]  i_alternate_offset_reg,
  input  wire        i_alt_window,
  input  wire        i_mapping_control_reg,
  input  wire        i_misc_mode_page,
  input  wire        i_page_select_bit,
  input  wire        i_gr6_map_b3,
  input  wire        i_gr6_map_b2,
  input  wire        i_crtc17_b5,
  input  wire [1:0]  i_access_mode,
  input  wire        i_text_mode,
  input  wire        i_packed_mode,
  input  wire        i_seq_half_clk,
  // Addresses
  input  wire [19:0] i_host_addr,
  input  wire [17:0] i_char_address_counter,
  input  wire        i_crt_cycle,
  output reg  [17:0] o_dram_address_bus,
  output reg         o_host_hit,
  output wire        o_rom_decode_en,
  // Attribute path
  input  wire [3:0]  i_attr_code,
  input  wire [3:0]  i_pel_pan,
  output reg  [1:0]  o_char_plane,
  output reg         o_underline,
  output reg  [3:0]  o_attr_bg,
  output reg  [3:0]  o_char_dots,
  output reg  [3:0]  o_pel_shift,
  // Pins and straps
  input  wire        i_memory_data_pin0,
  input  wire        i_strap_config3,
  output wire        o_wide_data_select_n,
  output reg         o_third_clock_select,
  output reg         o_video_clock_in_mux_lock,
  output reg         o_crtc_full_clk,
  output wire        o_compat_mode,
  output wire        o_alt_vendor_en
);

  // ----------------------------------------------------------------
  // Registers and synchronisers
  // ----------------------------------------------------------------
  reg  [7:0]  mem_cfg_q;        // Memory size/map config
  reg  [7:0]  vid_sel_q;        // Video select
  reg  [1:0]  md0_sync_q;       // Strap pin sync chain
  reg  [1:0]  cnf3_sync_q;      // Clock strap sync chain
  reg  [1:0]  strap_wait_q;     // Edges since release, strap waits for sync
  reg  [19:0] host_eff;         // Offset-modified host address
  reg  [1:0]  size_eff;         // Organisation after override
  reg  [17:0] cpu_ma;           // Host side mapping
  reg  [17:0] crt_ma;           // Display side mapping
  reg  [6:0]  ofs_sel;          // Chosen offset
  wire [3:0]  seg = i_host_addr[19:16];

  // ----------------------------------------------------------------
  // Strap and register writes
  // ----------------------------------------------------------------
  // Straps are sampled through two flops; the bit is loaded by a clocked
  // process after reset release so the async reset only sees constants.
  // The load waits until the chain holds the pin, else a pull-up would
  // be read as the chain's reset zero and map the ROM out.
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      md0_sync_q   <= 2'b00;
      cnf3_sync_q  <= 2'b00;
      strap_wait_q <= 2'b00;
      mem_cfg_q    <= `VMS_RST_BYTE;
      vid_sel_q    <= `VMS_RST_BYTE;
    end
    else
    begin
      md0_sync_q   <= {md0_sync_q[0], i_memory_data_pin0};
      cnf3_sync_q  <= {cnf3_sync_q[0], i_strap_config3};
      if (strap_wait_q != 2'b11)
        strap_wait_q <= strap_wait_q + 2'b01;
      if (strap_wait_q == 2'b10)
      begin
        // Pull-up reads high and latches zero
        mem_cfg_q[`VMS_MC_ROM_OUT] <= ~md0_sync_q[1];
      end
      else if (strap_wait_q == 2'b11 && i_reg_wr && i_reg_index == `VMS_IDX_MEM_CFG)
      begin
        // Reserved bit is held at zero
        mem_cfg_q <= i_reg_wdata & 8'hFD;
      end
      if (i_reg_wr && i_reg_index == `VMS_IDX_VID_SEL)
      begin
        vid_sel_q <= i_reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped indices read zero
  always @*
  begin
    case (i_reg_index)
      `VMS_IDX_MEM_CFG: o_reg_rdata = mem_cfg_q;
      `VMS_IDX_VID_SEL: o_reg_rdata = vid_sel_q;
      default:          o_reg_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Host offset and window decode
  // ----------------------------------------------------------------
  always @*
  begin
    // Alternate offset only while enabled and window picks it
    if (mem_cfg_q[`VMS_MC_ALT_EN] && i_alt_window)
      ofs_sel = i_alternate_offset_reg;
    else
      ofs_sel = i_primary_offset_reg;
    host_eff        = i_host_addr;
    host_eff[18:12] = i_host_addr[18:12] + ofs_sel;
    // Window decode by map field
    case (mem_cfg_q[`VMS_MC_MAP_HI:`VMS_MC_MAP_LO])
      `VMS_MAP_64K:  o_host_hit = (seg >= `VMS_SEG_A000) && (seg < `VMS_SEG_C000);
      `VMS_MAP_256K: o_host_hit = (seg < `VMS_SEG_4000);
      `VMS_MAP_512K: o_host_hit = (seg < `VMS_SEG_8000);
      default:       o_host_hit = 1'b1;
    endcase
    // Standard mapping forced by the control bit
    size_eff = i_mapping_control_reg ? `VMS_SIZE_STD
                                     : mem_cfg_q[`VMS_MC_SIZE_HI:`VMS_MC_SIZE_LO];
  end

  // ----------------------------------------------------------------
  // DRAM address multiplexer
  // ----------------------------------------------------------------
  // Bits 15..2 share one shift per mode for all organisations
  always @*
  begin
    cpu_ma = 18'h0_0000;
    crt_ma = 18'h0_0000;
    case (i_access_mode)
      `VMS_MODE_WORD:
      begin
        cpu_ma[15:1] = host_eff[15:1];
        crt_ma[15:1] = i_char_address_counter[14:0];
      end
      `VMS_MODE_DWORD:
      begin
        cpu_ma[15:2] = host_eff[15:2];
        crt_ma[15:2] = i_char_address_counter[13:0];
      end
      default:
      begin
        cpu_ma[15:0] = host_eff[15:0];
        crt_ma[15:0] = i_char_address_counter[15:0];
      end
    endcase
    case (size_eff)
      `VMS_SIZE_STD:
      begin
        if (i_access_mode == `VMS_MODE_WORD)
        begin
          cpu_ma[0] = (i_gr6_map_b3 || i_gr6_map_b2) ? i_page_select_bit
                                                     : host_eff[16];
          crt_ma[0] = i_crtc17_b5 ? i_char_address_counter[15]
                                  : i_char_address_counter[13];
        end
        else if (i_access_mode == `VMS_MODE_DWORD)
        begin
          cpu_ma[1:0] = host_eff[15:14];
          crt_ma[1:0] = i_char_address_counter[13:12];
        end
      end
      `VMS_SIZE_EXT256, `VMS_SIZE_512:
      begin
        if (i_access_mode == `VMS_MODE_WORD)
        begin
          cpu_ma[0] = host_eff[16];
          crt_ma[0] = i_char_address_counter[15];
        end
        else if (i_access_mode == `VMS_MODE_DWORD)
        begin
          cpu_ma[1:0] = host_eff[17:16];
          crt_ma[1:0] = i_char_address_counter[15:14];
        end
        if (size_eff == `VMS_SIZE_512)
        begin
          crt_ma[16] = i_char_address_counter[16];
          case (i_access_mode)
            `VMS_MODE_WORD:  cpu_ma[16] = host_eff[17];
            `VMS_MODE_DWORD: cpu_ma[16] = host_eff[18];
            default:         cpu_ma[16] = host_eff[16];
          endcase
        end
      end
      default:
      begin
        cpu_ma[17:16] = host_eff[17:16];
        case (i_access_mode)
          `VMS_MODE_WORD:
          begin
            crt_ma[17:16] = i_char_address_counter[16:15];
            cpu_ma[0]     = host_eff[18];
            crt_ma[0]     = i_char_address_counter[17];
          end
          `VMS_MODE_DWORD:
          begin
            crt_ma[17:16] = i_char_address_counter[15:14];
            cpu_ma[1:0]   = host_eff[19:18];
            crt_ma[1:0]   = i_char_address_counter[17:16];
          end
          default:
          begin
            crt_ma[17:16] = i_char_address_counter[17:16];
          end
        endcase
      end
    endcase
  end

  // Registered so the DRAM pins see clean edges
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_dram_address_bus <= 18'h0_0000;
    else
      o_dram_address_bus <= i_crt_cycle ? crt_ma : cpu_ma;
  end

  // ----------------------------------------------------------------
  // Simple control outputs
  // ----------------------------------------------------------------
  assign o_rom_decode_en      = ~mem_cfg_q[`VMS_MC_ROM_OUT];
  // Active only for text and packed pixel; planar stays high
  assign o_wide_data_select_n = ~(mem_cfg_q[`VMS_MC_WIDE] &
                                  (i_text_mode | i_packed_mode));
  assign o_compat_mode        = vid_sel_q[`VMS_VS_COMPAT];
  assign o_alt_vendor_en      = vid_sel_q[`VMS_VS_ALT_VEND];

  // ----------------------------------------------------------------
  // Attribute, character and clock outputs
  // ----------------------------------------------------------------
  // Data outputs registered; strap read from the synchronised copy
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_char_plane         <= `VMS_PLANE2;
      o_underline          <= 1'b0;
      o_attr_bg            <= 4'h0;
      o_char_dots          <= 4'h0;
      o_pel_shift          <= 4'h0;
      o_third_clock_select <= 1'b0;
      o_video_clock_in_mux_lock      <= 1'b0;
      o_crtc_full_clk      <= 1'b0;
    end
    else
    begin
      // Page mode forces plane 2 over the map select
      if (i_misc_mode_page)
        o_char_plane <= `VMS_PLANE2;
      else if (vid_sel_q[`VMS_VS_MAP_SEL] && vid_sel_q[`VMS_VS_ULINE])
        o_char_plane <= i_attr_code[3] ? `VMS_PLANE3 : `VMS_PLANE2;
      else if (vid_sel_q[`VMS_VS_MAP_SEL])
        o_char_plane <= `VMS_PLANE3;
      else
        o_char_plane <= `VMS_PLANE2;
      // Trade background bit 3 for underline
      o_underline <= vid_sel_q[`VMS_VS_ULINE] & i_attr_code[0];
      o_attr_bg   <= vid_sel_q[`VMS_VS_ULINE] ? {1'b0, i_attr_code[2:0]}
                                               : i_attr_code;
      // Zero means standard width, chosen by the sequencer
      if (!i_text_mode)
        o_char_dots <= 4'h0;
      else
        case (vid_sel_q[`VMS_VS_CCLK_HI:`VMS_VS_CCLK_LO])
          `VMS_CCLK_7:  o_char_dots <= `VMS_DOTS_7;
          `VMS_CCLK_9:  o_char_dots <= `VMS_DOTS_9;
          `VMS_CCLK_10: o_char_dots <= `VMS_DOTS_10;
          default:      o_char_dots <= 4'h0;
        endcase
      // Ten-dot panning translation; other widths pass through
      if (i_text_mode && vid_sel_q[`VMS_VS_CCLK_HI:`VMS_VS_CCLK_LO] == `VMS_CCLK_10)
      begin
        if (i_pel_pan == `VMS_PAN_ZERO10)
          o_pel_shift <= 4'h0;
        else if (i_pel_pan == `VMS_PAN_ONE10)
          o_pel_shift <= 4'h1;
        else
          o_pel_shift <= i_pel_pan + `VMS_PAN_BASE10;
      end
      else
        o_pel_shift <= i_pel_pan;
      o_third_clock_select <= cnf3_sync_q[1] & vid_sel_q[`VMS_VS_CLK_SEL];
      o_video_clock_in_mux_lock      <= ~cnf3_sync_q[1] & vid_sel_q[`VMS_VS_CLK_SEL];
      o_crtc_full_clk      <= vid_sel_q[`VMS_VS_FORCE_CLK] | ~i_seq_half_clk;
    end
  end

endmodule // vms_memory_map_select

/* File: sim/vms_far_side_model.sv */
`timescale 1ns/1ns
module vms_far_side_model
(
  // Board strap level
  input  wire i_strap_level,
  // Pins seen by the controller
  output wire o_memory_data_pin0,
  output wire o_strap_config3
);
  // -------------------------------------------------------------
  // Board straps
  // -------------------------------------------------------------
  // No part drives data pin 0 after power-up, so its pull-up wins
  assign o_memory_data_pin0 = 1'b1;
  // High when an external clock chip takes the third select line
  assign o_strap_config3    = i_strap_level;
endmodule // vms_far_side_model

/* File: sim/vms_memory_map_select_sva.sv */
`timescale 1ns/1ns
`include "vms_defines.vh"
module vms_map_select_sva
(
  // Clock, reset and register port
  input wire        i_sys_clk, i_rst_n, i_reg_wr,
  input wire [7:0]  i_reg_index, i_reg_wdata, o_reg_rdata,
  // Mode and address inputs
  input wire [6:0]  i_primary_offset_reg, i_alternate_offset_reg,
  input wire        i_alt_window, i_mapping_control_reg, i_misc_mode_page, i_page_select_bit,
  input wire        i_gr6_map_b3, i_gr6_map_b2, i_crtc17_b5, i_text_mode, i_packed_mode,
  input wire        i_seq_half_clk, i_crt_cycle, i_strap_config3,
  input wire [1:0]  i_access_mode, o_char_plane,
  input wire [19:0] i_host_addr,
  input wire [17:0] i_char_address_counter, o_dram_address_bus,
  input wire [3:0]  i_attr_code, i_pel_pan, o_attr_bg, o_char_dots, o_pel_shift,
  // Observed single-bit outputs
  input wire        o_host_hit, o_rom_decode_en, o_underline, o_wide_data_select_n,
  input wire        o_third_clock_select, o_video_clock_in_mux_lock, o_crtc_full_clk, o_compat_mode,
  input wire        o_alt_vendor_en
);
  // -------------------------------------------------------------
  // Shadow registers and expected values
  // -------------------------------------------------------------
  reg  [7:0]  cfg_q;   // Config copy, strap and reserved bits left out
  reg  [7:0]  vs_q;    // Video select copy
  reg  [19:0] am;      // Offset-modified host address
  reg  [17:0] ma_x;    // Expected dram address
  reg  [1:0]  sz;      // Effective organisation
  reg  [2:0]  k;       // Doubleword pair step
  reg  [2:0]  hw;      // Word fold step
  reg  [3:0]  dots_x;  // Expected dot width
  wire [17:0] ca  = i_char_address_counter;
  wire [3:0]  seg = i_host_addr[19:16];

  // Follow writes as the design takes them
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_q <= 8'h00;
      vs_q  <= 8'h00;
    end
    else if (i_reg_wr && i_reg_index == `VMS_IDX_MEM_CFG)
      cfg_q <= i_reg_wdata & 8'hFC;
    else if (i_reg_wr && i_reg_index == `VMS_IDX_VID_SEL)
      vs_q <= i_reg_wdata;
  end

  // Mux model; the low pair folds per size and mode, the top pair is set per size
  always @*
  begin
    am = {i_host_addr[19], i_host_addr[18:12] + ((cfg_q[3] && i_alt_window) ?
          i_alternate_offset_reg : i_primary_offset_reg), i_host_addr[11:0]};
    sz = i_mapping_control_reg ? `VMS_SIZE_STD : cfg_q[7:6];
    k  = (sz == `VMS_SIZE_STD) ? 3'h0 : (sz == `VMS_SIZE_1024) ? 3'h4 : 3'h2;
    hw = (sz == `VMS_SIZE_1024) ? 3'h2 : 3'h0;
    ma_x = i_crt_cycle ? (ca << i_access_mode) : am[17:0];
    if (i_access_mode == `VMS_MODE_WORD)
      ma_x[0] = i_crt_cycle ? ((sz == `VMS_SIZE_STD && !i_crtc17_b5) ? ca[13] : ca[15 + hw])
              : ((sz == `VMS_SIZE_STD && (i_gr6_map_b3 | i_gr6_map_b2)) ?
                 i_page_select_bit : am[16 + hw]);
    if (i_access_mode == `VMS_MODE_DWORD)
      ma_x[1:0] = i_crt_cycle ? ca[12 + k +: 2] : am[14 + k +: 2];
    if (sz != `VMS_SIZE_1024)
      ma_x[17:16] = {1'b0, (sz == `VMS_SIZE_512) &
                     (i_crt_cycle ? ca[16] : am[16 + i_access_mode])};
    dots_x = (vs_q[4:3] == `VMS_CCLK_7) ? `VMS_DOTS_7 : (vs_q[4:3] == `VMS_CCLK_9) ?
             `VMS_DOTS_9 : (vs_q[4:3] == `VMS_CCLK_10) ? `VMS_DOTS_10 : 4'h0;
    if (!i_text_mode)
      dots_x = 4'h0;
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Strap and bit held long enough to cross the two-flop sync
  sequence s_ext_clk;
    (i_strap_config3 && vs_q[1])[*4];
  endsequence
  sequence s_int_lock;
    (!i_strap_config3 && vs_q[1])[*4];
  endsequence

  a_ma_small_org: assert property (
    (sz <= `VMS_SIZE_EXT256 && i_access_mode != 2'h3) |=> o_dram_address_bus == $past(ma_x))
    else $error("dram address wrong in 256K organisation");
  a_ma_large_org: assert property (
    (sz >= `VMS_SIZE_512 && i_access_mode != 2'h3) |=> o_dram_address_bus == $past(ma_x))
    else $error("dram address wrong in large organisation");
  a_host_window: assert property (o_host_hit == ((cfg_q[5:4] == `VMS_MAP_64K) ?
    (seg == `VMS_SEG_A000 || seg == 4'hB) : (cfg_q[5:4] == `VMS_MAP_1024K) ||
    (seg < ((cfg_q[5:4] == `VMS_MAP_256K) ? `VMS_SEG_4000 : `VMS_SEG_8000))))
    else $error("host window decode wrong");
  a_wide_sel_n: assert property (
    o_wide_data_select_n == !(cfg_q[2] && (i_text_mode || i_packed_mode)))
    else $error("wide data select wrong");
  a_rom_map_out: assert property ((i_reg_index == `VMS_IDX_MEM_CFG) |->
    (o_reg_rdata[1] == 1'b0 && o_rom_decode_en == !o_reg_rdata[0]))
    else $error("rom decode or reserved bit wrong");
  a_vendor_bits: assert property (o_compat_mode == vs_q[6] && o_alt_vendor_en == vs_q[7] &&
    (i_reg_index != `VMS_IDX_VID_SEL || o_reg_rdata == vs_q))
    else $error("video select bits wrong");
  a_plane_pick: assert property (1'b1 |=> o_char_plane ==
    ($past(i_misc_mode_page || !vs_q[5] || (vs_q[2] && !i_attr_code[3])) ?
     `VMS_PLANE2 : `VMS_PLANE3))
    else $error("character plane wrong");
  a_char_dots: assert property (1'b1 |=> o_char_dots == $past(dots_x))
    else $error("character width wrong");
  a_ten_dot_pan: assert property ((dots_x == `VMS_DOTS_10 && i_pel_pan <= 4'h9) |=>
    o_pel_shift == $past((i_pel_pan == `VMS_PAN_ZERO10) ? 4'h0 : (i_pel_pan ==
    `VMS_PAN_ONE10) ? 4'h1 : i_pel_pan + `VMS_PAN_BASE10))
    else $error("ten dot panning wrong");
  a_uline_odd: assert property (1'b1 |=> o_underline == $past(vs_q[2] && i_attr_code[0]) &&
    (!$past(vs_q[2]) || !o_attr_bg[3]))
    else $error("underline or background wrong");
  a_clk_ext: assert property (s_ext_clk |-> o_third_clock_select && !o_video_clock_in_mux_lock)
    else $error("third clock select wrong");
  a_clk_lock: assert property (s_int_lock |-> o_video_clock_in_mux_lock)
    else $error("clock mux lock wrong");
  a_full_clk: assert property (1'b1 |=> o_crtc_full_clk == $past(vs_q[0] || !i_seq_half_clk))
    else $error("crtc clock choice wrong");
endmodule // vms_map_select_sva

bind vms_memory_map_select vms_map_select_sva vms_map_select_sva_i (.*);

/* File: sim/vms_memory_map_select_tb.sv */
`timescale 1ns/1ns
`include "vms_defines.vh"
module vms_memory_map_select_tb;
  // -------------------------------------------------------------
  // Stimulus, observed signals and bookkeeping
  // -------------------------------------------------------------
  reg         i_sys_clk, i_rst_n, i_reg_wr, strap_level;
  reg  [7:0]  i_reg_index, i_reg_wdata;
  reg  [6:0]  i_primary_offset_reg, i_alternate_offset_reg;
  reg         i_alt_window, i_mapping_control_reg, i_misc_mode_page, i_page_select_bit;
  reg         i_gr6_map_b3, i_gr6_map_b2, i_crtc17_b5, i_text_mode, i_packed_mode;
  reg         i_seq_half_clk, i_crt_cycle;
  reg  [1:0]  i_access_mode;
  reg  [19:0] i_host_addr;
  reg  [17:0] i_char_address_counter;
  reg  [3:0]  i_attr_code, i_pel_pan;
  wire [7:0]  o_reg_rdata;
  wire [17:0] o_dram_address_bus;
  wire [3:0]  o_attr_bg, o_char_dots, o_pel_shift;
  wire [1:0]  o_char_plane;
  wire        o_host_hit, o_rom_decode_en, o_underline, o_wide_data_select_n;
  wire        o_third_clock_select, o_video_clock_in_mux_lock, o_crtc_full_clk, o_compat_mode;
  wire        o_alt_vendor_en, i_memory_data_pin0, i_strap_config3;
  integer     failures, checks_done, seed, n;
  reg  [95:0] r;             // Random word for one cycle
  reg  [66:0] tbl [0:7];     // Config, mode, side, host, counter, expected

  vms_memory_map_select vms_memory_map_select_i (.*);
  vms_far_side_model vms_far_side_model_i (.i_strap_level(strap_level),
    .o_memory_data_pin0(i_memory_data_pin0), .o_strap_config3(i_strap_config3));

  // -------------------------------------------------------------
  // Tasks and expectation functions
  // -------------------------------------------------------------
  task chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // Write is taken at the second edge
  task wr(input logic [7:0] idx, input logic [7:0] d);
  begin
    @(posedge i_sys_clk);
    i_reg_wr    <= 1'b1;
    i_reg_index <= idx;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr    <= 1'b0;
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  function [3:0] dots(input logic [1:0] c);
    dots = (c == 2'h0) ? 4'h0 : (c == 2'h1) ? 4'h7 : (c == 2'h2) ? 4'h9 : 4'hA;
  endfunction
  function [3:0] pan10(input logic [3:0] p);
    pan10 = (p == 4'h9) ? 4'h0 : (p == 4'h8) ? 4'h1 : p + 4'h2;
  endfunction

  // -------------------------------------------------------------
  // Clock and watchdog
  // -------------------------------------------------------------
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Whole run is under a thousand cycles
  initial
  begin
    #100_000;
    failures = failures + 1;
    give_verdict;
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    seed = 80;
    failures = 0;
    checks_done = 0;
    {i_rst_n, i_reg_wr, i_reg_index, i_reg_wdata, i_primary_offset_reg, i_alternate_offset_reg,
     i_alt_window, i_mapping_control_reg, i_misc_mode_page, i_page_select_bit, i_gr6_map_b3,
     i_gr6_map_b2, i_crtc17_b5, i_text_mode, i_packed_mode, i_seq_half_clk, i_crt_cycle,
     strap_level, i_access_mode, i_host_addr, i_char_address_counter, i_attr_code,
     i_pel_pan} = 0;
    tbl[0] = {8'h00, 2'h1, 1'h0, 20'h3_0002, 18'h0_0000, 18'h0_0003};
    tbl[1] = {8'hC0, 2'h2, 1'h0, 20'hC_0004, 18'h0_0000, 18'h0_0007};
    tbl[2] = {8'h80, 2'h2, 1'h0, 20'h4_0000, 18'h0_0000, 18'h1_0000};
    tbl[3] = {8'h40, 2'h2, 1'h1, 20'h0_0000, 18'h0_C000, 18'h0_0003};
    tbl[4] = {8'h00, 2'h1, 1'h1, 20'h0_0000, 18'h0_2000, 18'h0_4001};
    tbl[5] = {8'h00, 2'h2, 1'h1, 20'h0_0000, 18'h0_3001, 18'h0_C007};
    tbl[6] = {8'hC0, 2'h1, 1'h1, 20'h0_0000, 18'h2_0001, 18'h0_0003};
    tbl[7] = {8'h40, 2'h1, 1'h0, 20'h1_0000, 18'h0_0000, 18'h0_0001};
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    // Pulled-up strap leaves the ROM mapped in
    i_reg_index <= `VMS_IDX_MEM_CFG;
    #1;
    chk("config reset", o_reg_rdata, 8'h00);
    chk("rom decode", o_rom_decode_en, 1'b1);
    // Corner cases of every organisation in word or doubleword mode, host or display side; 512K only doubleword, host side
    for (n = 0; n < 8; n = n + 1)
    begin
      wr(`VMS_IDX_MEM_CFG, tbl[n][66:59]);
      {i_access_mode, i_crt_cycle, i_host_addr, i_char_address_counter} <= tbl[n][58:18];
      @(posedge i_sys_clk);
      #1;
      chk("dram address", o_dram_address_bus, tbl[n][17:0]);
    end
    // Reserved bit refused, unmapped index ignored
    wr(`VMS_IDX_MEM_CFG, 8'h02);
    wr(8'h0D, 8'hFF);
    i_reg_index <= 8'h0D;
    #1;
    chk("unmapped read", o_reg_rdata, 8'h00);
    i_reg_index <= `VMS_IDX_MEM_CFG;
    #1;
    chk("reserved bit", o_reg_rdata, 8'h00);
    // Every character width, then ten-dot panning
    i_text_mode <= 1'b1;
    for (n = 0; n < 4; n = n + 1)
    begin
      wr(`VMS_IDX_VID_SEL, {3'h0, n[1:0], 3'h0});
      i_reg_index <= `VMS_IDX_VID_SEL;
      @(posedge i_sys_clk);
      #1;
      chk("video select", o_reg_rdata, {3'h0, n[1:0], 3'h0});
      chk("char dots", o_char_dots, dots(n[1:0]));
    end
    for (n = 0; n < 10; n = n + 1)
    begin
      i_pel_pan <= n[3:0];
      @(posedge i_sys_clk);
      #1;
      chk("pel shift", o_pel_shift, pan10(n[3:0]));
    end
    // Plane table and underline over the map and underline selects and attribute bits 3 and 0, then page mode once with all clear
    for (n = 0; n < 17; n = n + 1)
    begin
      wr(`VMS_IDX_VID_SEL, {2'h0, n[3], 2'h0, n[2], 2'h0});
      i_attr_code <= {n[1], 2'h0, n[0]};
      i_misc_mode_page <= n[4];
      @(posedge i_sys_clk);
      #1;
      chk("char plane", o_char_plane, (n[3] && !(n[2] && !n[1]) && !n[4]) ? 2'h3 : 2'h2);
      chk("underline", o_underline, n[2] & n[0]);
      chk("background bit", o_attr_bg[3], n[1] & !n[2]);
    end
    // Random traffic with writes among it
    for (n = 0; n < 600; n = n + 1)
    begin
      @(posedge i_sys_clk);
      r = {$random(seed), $random(seed), $random(seed)};
      {i_primary_offset_reg, i_alternate_offset_reg, i_host_addr, i_char_address_counter,
       i_attr_code, i_pel_pan, i_alt_window, i_mapping_control_reg, i_misc_mode_page,
       i_page_select_bit, i_gr6_map_b3, i_gr6_map_b2, i_crtc17_b5, i_text_mode,
       i_packed_mode, i_seq_half_clk, i_crt_cycle} <= r[70:0];
      i_access_mode <= (r[73:72] == 2'h3) ? 2'h2 : r[73:72];
      i_reg_wr      <= (r[76:74] == 3'h0);
      i_reg_index   <= r[77] ? `VMS_IDX_VID_SEL : `VMS_IDX_MEM_CFG;
      i_reg_wdata   <= r[95:88];
      if (r[83:78] == 6'h00)
        strap_level <= ~strap_level;
    end
    give_verdict;
  end
endmodule // vms_memory_map_select_tb
